// *** sim/iows_bridge_chk.sv ***
// port assertions for the i/o wait and strobe delay glue
`timescale 1ns/1ps
`default_nettype none
`include "iows_map.svh"
module iows_bridge_chk
    import iows_pkg::*;
(
    input wire logic            ref_clk,
    input wire logic            rst,
    input wire iows_cpu_type    cpu_in,
    input wire logic            fast_grade,
    input wire logic            wait_all_io,
    input wire iows_periph_type periph_out,
    input wire logic            wait_n
);
    // pin to output is two sync flops plus the output register
    wire hit = !cpu_in.io_request_n &&
        (cpu_in.addr & `IOWS_PERIPH_MASK) == `IOWS_PERIPH_BASE;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_ce_decode: assert property (
        periph_out.chip_enable_n == !$past(hit, 3)) else $error("ce bad");
    a_rd_delay: assert property (
        periph_out.rd_n == !$past(hit && !cpu_in.rd_n, 3)) else $error("rd");
    a_wr_delay: assert property (
        periph_out.wr_n == !$past(hit && !cpu_in.wr_n, 3)) else $error("wr");
    a_strobe_late: assert property (
        $fell(cpu_in.rd_n) |-> periph_out.rd_n [*3]) else $error("early");
    a_wait_fast: assert property (
        $fell(wait_n) && fast_grade |=> wait_n)
        else $error("fast wait length");
    a_wait_std: assert property (
        $fell(wait_n) && !fast_grade |=> !wait_n ##1 wait_n)
        else $error("std wait length");
    a_wait_cause: assert property (
        $fell(wait_n) |-> (wait_all_io || !periph_out.chip_enable_n) &&
        $past(!cpu_in.io_request_n && !(cpu_in.rd_n && cpu_in.wr_n), 3))
        else $error("wait cause");
    a_idle_clear: assert property (
        $past(cpu_in.io_request_n, 3) |-> wait_n && periph_out == 3'b111)
        else $error("idle");
endmodule : iows_bridge_chk
bind iows_bridge iows_bridge_chk u_chk (.ref_clk, .rst, .cpu_in,
    .fast_grade, .wait_all_io, .periph_out, .wait_n);
`default_nettype wire

// *** sim/iows_periph_model.sv ***
// peripheral model: counts selected strobes and their low width
`timescale 1ns/1ps
`default_nettype none
module iows_periph_model
    import iows_pkg::*;
(
    input wire logic            ref_clk,
    input wire iows_periph_type periph,
    output var int              hits,
    output var int              width
);
    logic was_low = 1'b0;
    // a strobe without chip enable is ignored, as a real part would
    wire low = !periph.chip_enable_n && !(periph.rd_n && periph.wr_n);
    always @(posedge ref_clk) begin
        hits <= hits + int'(low && !was_low);
        width <= low ? (was_low ? width + 1 : 1) : width;
        was_low <= low;
    end
endmodule : iows_periph_model
`default_nettype wire

// *** sim/testbench.sv ***
// testbench for the i/o wait and strobe delay glue
`timescale 1ns/1ps
`default_nettype none
module testbench
    import iows_pkg::*;
;
    logic            ref_clk = 1'b0;
    logic            rst = 1'b1;
    iows_cpu_type    cpu_in = '{1'b1, 1'b1, 1'b1, 8'h00};
    logic            fast_grade = 1'b1;
    logic            wait_all_io = 1'b0;
    iows_periph_type periph_out;
    logic            wait_n;
    int              hits, width, fails = 0, total_checks = 0;
    always #20 ref_clk = ~ref_clk;
    iows_bridge dut (.ref_clk, .rst, .cpu_in, .fast_grade, .wait_all_io,
        .periph_out, .wait_n);
    iows_periph_model model (.ref_clk, .periph(periph_out), .hits, .width);
    task automatic check(input string what, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // cpu holds each cycle ten clocks, longer than any wait
    task automatic io_cycle(input logic rd, f, all, input logic [7:0] a,
        waits, hit);
        int n0;
        logic [7:0] n;
        n = 8'h00;
        n0 = hits;
        @(negedge ref_clk);
        fast_grade = f;
        wait_all_io = all;
        cpu_in = '{1'b0, !rd, rd, a};
        repeat (10) @(negedge ref_clk) n += 8'(!wait_n);
        cpu_in = '{1'b1, 1'b1, 1'b1, a};
        repeat (5) @(negedge ref_clk);
        check("waits", n, waits);
        check("strobes", 8'(hits - n0), hit);
        if (hit) check("width", 8'(width), 8'h0a);
    endtask : io_cycle
    task automatic fast_cycles();
        io_cycle(1'b1, 1'b1, 1'b0, 8'hf3, 8'h01, 8'h01);
        io_cycle(1'b0, 1'b1, 1'b0, 8'hff, 8'h01, 8'h01);
    endtask : fast_cycles
    task automatic std_cycles();
        io_cycle(1'b1, 1'b0, 1'b0, 8'hf0, 8'h02, 8'h01);
        io_cycle(1'b0, 1'b0, 1'b0, 8'hf0, 8'h02, 8'h01);
    endtask : std_cycles
    task automatic decode_cycles();
        io_cycle(1'b1, 1'b1, 1'b0, 8'he0, 8'h00, 8'h00);
        io_cycle(1'b0, 1'b0, 1'b1, 8'h7f, 8'h02, 8'h00);
    endtask : decode_cycles
    task automatic summarize();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    initial begin
        repeat (4) @(negedge ref_clk);
        check("reset", {4'h0, wait_n, periph_out}, 8'h0f);
        rst = 1'b0;
        fast_cycles();
        std_cycles();
        decode_cycles();
        summarize();
    end
    initial begin
        #20000;
        fails++;
        summarize();
    end
endmodule : testbench
`default_nettype wire

// *** verilog/iows_bridge.sv ***
// cpu i/o cycle glue: strobe delay, chip enable and wait-state counter
`timescale 1ns/1ps
`default_nettype none
`include "iows_map.svh"

module iows_bridge
    import iows_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire iows_cpu_type cpu_in,
    input  wire logic         fast_grade,
    input  wire logic         wait_all_io,
    output var  iows_periph_type periph_out,
    output var  logic         wait_n
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage read only by the second
    iows_cpu_type sync1_reg;
    iows_cpu_type sync2_reg;
    logic [1:0]   mode1_reg;
    logic [1:0]   mode2_reg;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_reg <= '{io_request_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                           addr: 8'h00};
            sync2_reg <= '{io_request_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                           addr: 8'h00};
            mode1_reg <= 2'b00;
            mode2_reg <= 2'b00;
        end else begin
            sync1_reg <= cpu_in;
            sync2_reg <= sync1_reg;
            mode1_reg <= {fast_grade, wait_all_io};
            mode2_reg <= mode1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cycle detection
    logic addr_hit;
    logic periph_cycle;
    logic io_cycle;
    logic wait_cycle;

    always_comb begin
        addr_hit = (sync2_reg.addr & `IOWS_PERIPH_MASK)
                   == `IOWS_PERIPH_BASE;
        periph_cycle = !sync2_reg.io_request_n && addr_hit;
        io_cycle = !sync2_reg.io_request_n
                   && !(sync2_reg.rd_n && sync2_reg.wr_n);
        // waits for every i/o cycle or only ours
        wait_cycle = io_cycle && (mode2_reg[0] || addr_hit);
    end

    ////////////////////////////////////////////////////////////////////
    // strobe delay and wait counter
    iows_state_type             state_reg, state_next;
    logic [`IOWS_CNT_W-1:0]     cnt_reg, cnt_next;
    iows_periph_type            periph_reg, periph_next;
    logic                       wait_n_reg, wait_n_next;
    logic [`IOWS_CNT_W-1:0]     wait_target;

    always_comb begin
        // one count for reads and writes keeps the logic small
        wait_target = mode2_reg[1] ? `IOWS_CNT_W'(`IOWS_WAIT_FAST)
                                   : `IOWS_CNT_W'(`IOWS_WAIT_STD);
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        wait_n_next = 1'b1;
        periph_next.chip_enable_n = !periph_cycle;
        // strobes pass straight through after sync: fall and rise see the same delay
        periph_next.rd_n = !(periph_cycle && !sync2_reg.rd_n);
        periph_next.wr_n = !(periph_cycle && !sync2_reg.wr_n);
        unique case (state_reg)
            IOWS_IDLE: begin
                cnt_next = '0;
                if (wait_cycle) begin
                    state_next  = IOWS_WAIT;
                    wait_n_next = 1'b0;
                end
            end
            IOWS_WAIT: begin
                // counting clock pulses covers data delay and low width
                wait_n_next = 1'b0;
                cnt_next    = cnt_reg + `IOWS_CNT_W'(1);
                if (cnt_reg + `IOWS_CNT_W'(1) >= wait_target) begin
                    state_next  = IOWS_DONE;
                    wait_n_next = 1'b1;
                end
            end
            IOWS_DONE: begin
                if (!io_cycle) begin
                    state_next = IOWS_IDLE;
                end
            end
            IOWS_STROBE: begin
                state_next = IOWS_IDLE;
            end
        endcase
        // cycle dropped: clear state, count and wait_n so next cycle counts from zero
        if (!io_cycle) begin
            state_next  = IOWS_IDLE;
            cnt_next    = '0;
            wait_n_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg  <= IOWS_IDLE;
            cnt_reg    <= '0;
            periph_reg <= '{chip_enable_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
            wait_n_reg <= 1'b1;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            periph_reg <= periph_next;
            wait_n_reg <= wait_n_next;
        end
    end

    assign periph_out = periph_reg;
    assign wait_n     = wait_n_reg;

endmodule : iows_bridge
`default_nettype wire

// *** verilog/iows_map.svh ***
// offsets-free constant map for the i/o wait and strobe delay glue
`ifndef IOWS_MAP_SVH
`define IOWS_MAP_SVH

// cpu clock period in ns; wait states are set directly as counts, not from it
`define IOWS_CLK_PERIOD_NS 40
// extra wait states per i/o cycle: standard grade needs two, fast grade one
`define IOWS_WAIT_STD      2
`define IOWS_WAIT_FAST     1
`define IOWS_CNT_W         3
// decoded peripheral address match on low address byte
`define IOWS_PERIPH_BASE   8'hf0
`define IOWS_PERIPH_MASK   8'hf0

`endif

// *** verilog/iows_pkg.sv ***
// types for the i/o wait and strobe delay glue
`default_nettype none
package iows_pkg;
    typedef struct packed {
        logic       io_request_n;
        logic       rd_n;
        logic       wr_n;
        logic [7:0] addr;
    } iows_cpu_type;

    typedef struct packed {
        logic chip_enable_n;
        logic rd_n;
        logic wr_n;
    } iows_periph_type;

    typedef enum logic [1:0] {
        IOWS_IDLE  = 2'b00,
        IOWS_STROBE = 2'b01,
        IOWS_WAIT  = 2'b10,
        IOWS_DONE  = 2'b11
    } iows_state_type;
endpackage : iows_pkg
`default_nettype wire
